// [shared/ttws_defs.svh]
// Timing counts and field constants of the weld sequencer
`ifndef TTWS_DEFS_SVH
`define TTWS_DEFS_SVH
`define TTWS_CLK_HZ        20000000
`define TTWS_TICK_US       1000
`define TTWS_TICK_DIV      ((`TTWS_CLK_HZ / 1000000) * `TTWS_TICK_US)
`define TTWS_FAULT_S       5
`define TTWS_FAULT_TICKS   (`TTWS_FAULT_S * 1000000 / `TTWS_TICK_US)
`define TTWS_ARCLEN_MIN    8'shfb
`define TTWS_ARCLEN_MAX    8'sh05
`define TTWS_PRESET_N      16
`define TTWS_MAT_W         2
`define TTWS_DIA_W         1
`define TTWS_GAS_W         1
`define TTWS_PAR_RST       16'h0000
`endif

// [shared/ttws_pkg.sv]
// Types of the weld sequencer
package ttws_pkg;
  typedef enum logic [1:0]
  {
    TTWS_NONLATCHED,
    TTWS_SPECIAL_NONLATCHED,
    TTWS_LATCHED,
    TTWS_LATCHED_SPECIAL
  } ttws_mode_e;
  typedef enum logic [1:0]
  {
    TTWS_SHOW_CURRENT,
    TTWS_SHOW_THICKNESS,
    TTWS_SHOW_WIRE_SPEED,
    TTWS_SHOW_RSVD
  } ttws_show_e;
  typedef enum logic [1:0]
  {
    TTWS_PROG_MAIN,
    TTWS_PROG_START,
    TTWS_PROG_END
  } ttws_prog_e;
  typedef logic [3:0]  ttws_preset_t;
  typedef logic [15:0] ttws_time_t;
  typedef logic [31:0] ttws_cnt_t;
endpackage

// [shared/ttws_tick_if.sv]
// Slow timebase tick carried from divider to sequencer
`timescale 1ns/1ns
interface ttws_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// [src/ttws_seq.sv]
// Torch trigger weld sequencer top
`timescale 1ns/1ns
`include "ttws_defs.svh"
module ttws_seq
  import ttws_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  input  wire logic              trigger_i,
  input  wire logic              inch_i,
  input  wire logic              contact_i,
  input  wire logic              current_i,
  input  wire logic              arc_i,
  input  wire ttws_mode_e        mode_i,
  input  wire logic [1:0]        material_i,
  input  wire logic              diameter_i,
  input  wire logic              gas_type_i,
  input  wire logic              preset_load_i,
  input  wire ttws_show_e        show_i,
  input  wire logic              par_wr_i,
  input  wire logic [2:0]        par_sel_i,
  input  wire logic [15:0]       par_data_i,
  output logic                   gas_o,
  output logic                   motor_o,
  output logic [15:0]            wire_speed_o,
  output logic                   output_on_o,
  output ttws_prog_e             program_o,
  output logic                   ramping_o,
  output logic                   ignition_fault_o,
  output logic                   arc_fault_o,
  output ttws_preset_t           preset_o,
  output logic                   preset_reject_o,
  output logic signed [7:0]      arc_length_o,
  output logic signed [7:0]      dynamics_o,
  output ttws_show_e             show_o,
  output logic [15:0]            spot_duration_o,
  output logic [15:0]            pause_duration_o
);
  // Parameter selectors
  localparam logic [2:0] SEL_PRE   = 3'h0;
  localparam logic [2:0] SEL_BURN  = 3'h1;
  localparam logic [2:0] SEL_POST  = 3'h2;
  localparam logic [2:0] SEL_START = 3'h3;
  localparam logic [2:0] SEL_END   = 3'h4;
  localparam logic [2:0] SEL_ARC   = 3'h5;
  localparam logic [2:0] SEL_DYN   = 3'h6;
  localparam logic [2:0] SEL_GLOB  = 3'h7;
  localparam int          NPAR     = 7;
  typedef enum logic [3:0]
  {
    S_IDLE,
    S_INCH,
    S_PRE,
    S_CREEP,
    S_START,
    S_WELD,
    S_WAIT_PRESS,
    S_WAIT_REL,
    S_END,
    S_BURN,
    S_POST
  } ttws_state_e;
  typedef struct packed
  {
    ttws_state_e   st;
    ttws_cnt_t     tmr;
    ttws_cnt_t     flt;
    logic          trig_d1;
    logic          ign_f;
    logic          arc_f;
    logic          rej;
    ttws_preset_t  preset;
    ttws_show_e    show;
    logic [15:0]   spot;
    logic [15:0]   pause;
    logic [15:0]   wfs;
  } ttws_state_s;
  ttws_state_s  s_q;
  ttws_state_s  s_d;
  ttws_tick_if  tk ();
  // Per-preset parameter store, one word per parameter per preset
  logic [15:0] par_q [`TTWS_PRESET_N][NPAR];
  // ==========================================
  // Timebase
  ttws_tick_div u_div
  (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .tk      (tk)
  );
  // ==========================================
  // Helpers
  function automatic logic [15:0] par_of(input ttws_preset_t p, input logic [2:0] s);
    par_of = par_q[p][s];
  endfunction
  function automatic logic signed [7:0] clamp_arc(input logic [15:0] v);
    logic signed [15:0] sv;
    sv = signed'(v);
    if (sv < 16'(`TTWS_ARCLEN_MIN))
      clamp_arc = `TTWS_ARCLEN_MIN;
    else if (sv > 16'(`TTWS_ARCLEN_MAX))
      clamp_arc = `TTWS_ARCLEN_MAX;
    else
      clamp_arc = sv[7:0];
  endfunction
  // Preset number from basic parameters
  ttws_preset_t job_num;
  assign job_num = {material_i, diameter_i, gas_type_i};
  logic press;
  logic trig_rel;
  logic tmr_done;
  assign press    = trigger_i & ~s_q.trig_d1;
  assign trig_rel = ~trigger_i & s_q.trig_d1;
  assign tmr_done = (s_q.tmr == '0);
  // ==========================================
  // Sequencer next state
  always_comb
  begin
    s_d         = s_q;
    s_d.trig_d1 = trigger_i;
    s_d.rej     = 1'b0;
    if (tk.tick && !tmr_done)
      s_d.tmr = s_q.tmr - 32'h1;
    // Preset select, locked while current flows
    if (preset_load_i)
    begin
      if (current_i)
        s_d.rej = 1'b1;
      else
        s_d.preset = job_num;
    end
    s_d.show = show_i;
    // Shared settings
    if (par_wr_i && par_sel_i == SEL_GLOB)
      s_d.wfs = par_data_i;
    case (s_q.st)
      S_IDLE:
      begin
        s_d.flt = '0;
        if (inch_i && !contact_i)
          s_d.st = S_INCH;
        else if (press)
        begin
          s_d.ign_f = 1'b0;
          s_d.arc_f = 1'b0;
          s_d.st    = S_PRE;
          s_d.tmr   = 32'(par_of(s_q.preset, SEL_PRE));
        end
      end
      S_INCH:
        if (!inch_i || contact_i)
          s_d.st = S_IDLE;
      S_PRE:
        if (tmr_done)
        begin
          s_d.st  = S_CREEP;
          s_d.flt = 32'(`TTWS_FAULT_TICKS);
        end
      S_CREEP:
      begin
        if (tk.tick && s_q.flt != '0)
          s_d.flt = s_q.flt - 32'h1;
        if (current_i)
        begin
          s_d.flt = 32'(`TTWS_FAULT_TICKS);
          if (mode_i == TTWS_SPECIAL_NONLATCHED || mode_i == TTWS_LATCHED_SPECIAL)
          begin
            s_d.st  = S_START;
            s_d.tmr = 32'(par_of(s_q.preset, SEL_START));
          end
          else
            s_d.st = S_WELD;
        end
        else if (s_q.flt == '0)
        begin
          s_d.ign_f = 1'b1;
          s_d.st    = S_BURN;
          s_d.tmr   = '0;
        end
        else if (trig_rel && (mode_i == TTWS_NONLATCHED || mode_i == TTWS_SPECIAL_NONLATCHED))
          s_d.st = S_POST;
      end
      default:
      begin
        // Arc watchdog covers states S_START through S_END, not S_BURN
        if (s_q.st == S_START || s_q.st == S_WELD || s_q.st == S_WAIT_PRESS
            || s_q.st == S_WAIT_REL || s_q.st == S_END)
        begin
          if (arc_i)
            s_d.flt = 32'(`TTWS_FAULT_TICKS);
          else if (tk.tick && s_q.flt != '0)
            s_d.flt = s_q.flt - 32'h1;
          if (!arc_i && s_q.flt == '0)
          begin
            s_d.arc_f = 1'b1;
            s_d.st    = S_BURN;
            s_d.tmr   = '0;
          end
          else
          begin
            case (s_q.st)
              S_START:
                if (tmr_done)
                  s_d.st = S_WELD;
              S_WELD:
                if (mode_i == TTWS_LATCHED || mode_i == TTWS_LATCHED_SPECIAL)
                begin
                  if (trig_rel)
                    s_d.st = S_WAIT_PRESS;
                end
                else if (trig_rel)
                begin
                  if (mode_i == TTWS_SPECIAL_NONLATCHED)
                  begin
                    s_d.st  = S_END;
                    s_d.tmr = 32'(par_of(s_q.preset, SEL_END));
                  end
                  else
                  begin
                    s_d.st  = S_BURN;
                    s_d.tmr = 32'(par_of(s_q.preset, SEL_BURN));
                  end
                end
              S_WAIT_PRESS:
                if (press)
                  s_d.st = S_WAIT_REL;
              S_WAIT_REL:
                if (trig_rel)
                begin
                  s_d.st  = S_BURN;
                  s_d.tmr = 32'(par_of(s_q.preset, SEL_BURN));
                end
              S_END:
                if (tmr_done)
                begin
                  s_d.st  = S_BURN;
                  s_d.tmr = 32'(par_of(s_q.preset, SEL_BURN));
                end
              default:
                s_d.st = S_IDLE;
            endcase
          end
        end
        else if (s_q.st == S_BURN && tmr_done)
        begin
          s_d.st  = S_POST;
          s_d.tmr = 32'(par_of(s_q.preset, SEL_POST));
        end
        else if (s_q.st == S_POST && tmr_done)
          s_d.st = S_IDLE;
      end
    endcase
  end
  // ==========================================
  // State register
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s_q <= '0; // Idle state and current display are zero codes
    else
      s_q <= s_d;
  end
  // ==========================================
  // Parameter store, writes go to selected preset
  genvar gp;
  genvar gs;
  generate
    for (gp = 0; gp < `TTWS_PRESET_N; gp++)
    begin : g_pre
      for (gs = 0; gs < NPAR; gs++)
      begin : g_sel
        always_ff @(posedge mclk_i or negedge rst_b_i)
        begin
          if (!rst_b_i)
            par_q[gp][gs] <= `TTWS_PAR_RST;
          else if (par_wr_i && par_sel_i == 3'(gs) && s_q.preset == 4'(gp))
            par_q[gp][gs] <= (3'(gs) == SEL_ARC) ?
              16'(signed'(clamp_arc(par_data_i))) : par_data_i;
        end
      end
    end
  endgenerate
  // Spot and pause are shared settings
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      spot_duration_o  <= `TTWS_PAR_RST;
      pause_duration_o <= `TTWS_PAR_RST;
    end
    else if (par_wr_i && par_sel_i == SEL_GLOB && inch_i)
    begin
      spot_duration_o  <= par_data_i;
      pause_duration_o <= par_data_i;
    end
  end
  // ==========================================
  // Outputs
  always_comb
  begin
    gas_o        = (s_q.st inside {S_PRE, S_CREEP, S_START, S_WELD, S_WAIT_PRESS,
                    S_WAIT_REL, S_END, S_BURN, S_POST});
    motor_o      = (s_q.st inside {S_INCH, S_CREEP, S_START, S_WELD, S_WAIT_PRESS,
                    S_WAIT_REL, S_END});
    output_on_o  = (s_q.st inside {S_CREEP, S_START, S_WELD, S_WAIT_PRESS,
                    S_WAIT_REL, S_END, S_BURN});
    wire_speed_o = (s_q.st == S_CREEP || s_q.st == S_INCH) ? (s_q.wfs >> 1) : s_q.wfs;
    program_o    = (s_q.st == S_START) ? TTWS_PROG_START :
                   (s_q.st == S_END) ? TTWS_PROG_END : TTWS_PROG_MAIN;
    ramping_o    = (s_q.st == S_END);
  end
  assign ignition_fault_o = s_q.ign_f;
  assign arc_fault_o      = s_q.arc_f;
  assign preset_o         = s_q.preset;
  assign preset_reject_o  = s_q.rej;
  assign arc_length_o     = par_q[s_q.preset][SEL_ARC][7:0];
  assign dynamics_o       = signed'(par_q[s_q.preset][SEL_DYN][7:0]);
  assign show_o           = s_q.show;
endmodule // ttws_seq

// [src/ttws_tick_div.sv]
// Divider making the slow timebase tick
`timescale 1ns/1ns
`include "ttws_defs.svh"
module ttws_tick_div
  import ttws_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  rst_b_i,
  ttws_tick_if.src   tk
);
  typedef struct packed
  {
    logic [15:0] cnt;
    logic        tick;
  } ttws_div_s;
  ttws_div_s st_q;
  ttws_div_s st_d;
  // ==========================================
  // Count down one tick period
  always_comb
  begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == 16'h0000)
    begin
      st_d.cnt  = 16'(`TTWS_TICK_DIV - 1);
      st_d.tick = 1'b1;
    end
    else
    begin
      st_d.cnt = st_q.cnt - 16'h0001;
    end
  end
  // Register
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign tk.tick = st_q.tick;
endmodule // ttws_tick_div

// [verif/test_torch_trigger_weld_sequencer.sv]
// Self-checking bench of the weld sequencer
`timescale 1ns/1ns
module test_torch_trigger_weld_sequencer
  import ttws_pkg::*;
;
  logic mclk_i = 0, rst_b_i = 0, trigger_i = 0, inch_i = 0, contact_i, current_i, arc_i;
  ttws_mode_e mode_i = TTWS_NONLATCHED;
  logic [1:0] material_i = 0;
  logic diameter_i = 0, gas_type_i = 0, preset_load_i = 0, par_wr_i = 0, away = 0, rej;
  ttws_show_e show_i = TTWS_SHOW_CURRENT;
  logic [2:0] par_sel_i = 0;
  logic [15:0] par_data_i = 0, wire_speed_o, spot_duration_o, pause_duration_o;
  logic gas_o, motor_o, output_on_o, ramping_o, ignition_fault_o, arc_fault_o, preset_reject_o;
  ttws_prog_e program_o;
  ttws_preset_t preset_o;
  logic signed [7:0] arc_length_o, dynamics_o;
  ttws_show_e show_o;
  int n_fail = 0, checks_done = 0;

  ttws_seq dut (.mclk_i, .rst_b_i, .trigger_i, .inch_i, .contact_i, .current_i, .arc_i, .mode_i,
    .material_i, .diameter_i, .gas_type_i, .preset_load_i, .show_i, .par_wr_i, .par_sel_i,
    .par_data_i, .gas_o, .motor_o, .wire_speed_o, .output_on_o, .program_o, .ramping_o,
    .ignition_fault_o, .arc_fault_o, .preset_o, .preset_reject_o, .arc_length_o, .dynamics_o,
    .show_o, .spot_duration_o, .pause_duration_o);
  ttws_torch_model #(.DLY(20)) u_torch (.mclk_i, .motor_i(motor_o), .output_on_i(output_on_o),
    .away_i(away), .contact_o(contact_i), .current_o(current_i), .arc_o(arc_i));

  // Clock of 50 ns
  always #25 mclk_i = ~mclk_i;

  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic obs(input int k);
    case (k)
      0: return gas_o;
      1: return current_i;
      2: return output_on_o;
      3: return program_o == TTWS_PROG_MAIN;
      4: return contact_i;
      5: return motor_o;
      default: return ramping_o;
    endcase
  endfunction
  task automatic wt(input int k, input logic v);
    int i;
    for (i = 0; i < 30000 && obs(k) !== v; i++)
      @(negedge mclk_i);
    if (i == 30000)
    begin
      n_fail++;
      $display("[FAIL] %0t wait %0d timed out", $time, k);
      print_verdict();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    cyc(1);
    par_wr_i = 1;
    par_sel_i = s;
    par_data_i = d;
    cyc(1);
    par_wr_i = 0;
    cyc(1);
  endtask
  task automatic ld(input logic [3:0] p);
    cyc(1);
    {material_i, diameter_i, gas_type_i} = p;
    preset_load_i = 1;
    cyc(1);
    preset_load_i = 0;
    rej = preset_reject_o;
    cyc(1);
  endtask
  task automatic lift();
    away = 1;
    cyc(2);
    away = 0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_setup();
    for (int s = 0; s < 5; s++)
      wr(3'(s), 16'(s / 3));
    inch_i = 1;
    wr(3'h7, 16'h0040);
    inch_i = 0;
    chk(spot_duration_o, 16'h0040);
    chk(pause_duration_o, 16'h0040);
    wr(3'h5, 16'h0064);
    chk({8'h00, arc_length_o}, 16'h0005);
    wr(3'h5, 16'hff9c);
    chk({8'h00, arc_length_o}, 16'h00fb);
    wr(3'h5, 16'h0003);
    wr(3'h6, 16'hfffe);
    chk({8'h00, dynamics_o}, 16'h00fe);
    ld(4'h5);
    chk(preset_o, 16'h0005);
    wr(3'h5, 16'hffff);
    ld(4'h0);
    chk({8'h00, arc_length_o}, 16'h0003);
    for (int m = 0; m < 3; m++)
    begin
      show_i = ttws_show_e'(m);
      cyc(2);
      chk(show_o, 16'(m));
    end
    $display("test setup done");
  endtask
  task automatic test_inch();
    inch_i = 1;
    wt(4, 1);
    cyc(2);
    chk(motor_o, 1'b0);
    inch_i = 0;
    lift();
    $display("test inch done");
  endtask
  task automatic test_nonlatched();
    mode_i = TTWS_NONLATCHED;
    trigger_i = 1;
    wt(5, 1);
    chk(wire_speed_o, 16'h0020);
    wt(1, 1);
    cyc(2);
    chk(wire_speed_o, 16'h0040);
    ld(4'h9);
    chk(rej, 1'b1);
    chk(preset_o, 16'h0000);
    trigger_i = 0;
    cyc(1);
    chk({motor_o, output_on_o}, 16'h0001);
    wt(2, 0);
    chk(gas_o, 1'b1);
    wt(0, 0);
    chk({ignition_fault_o, arc_fault_o}, 16'h0000);
    lift();
    $display("test nonlatched done");
  endtask
  task automatic test_latched(input ttws_mode_e m);
    mode_i = m;
    trigger_i = 1;
    wt(1, 1);
    cyc(2);
    wt(3, 1);
    chk(wire_speed_o, 16'h0040);
    trigger_i = 0;
    cyc(5);
    chk(motor_o, 1'b1);
    trigger_i = 1;
    cyc(5);
    chk(motor_o, 1'b1);
    trigger_i = 0;
    cyc(1);
    chk({motor_o, output_on_o}, 16'h0001);
    wt(0, 0);
    lift();
    $display("test latched done");
  endtask
  task automatic test_special();
    mode_i = TTWS_SPECIAL_NONLATCHED;
    trigger_i = 1;
    wt(1, 1);
    cyc(2);
    chk(program_o, TTWS_PROG_START);
    wt(3, 1);
    trigger_i = 0;
    cyc(2);
    chk({ramping_o, motor_o}, 16'h0003);
    chk(program_o, TTWS_PROG_END);
    wt(6, 0);
    chk({motor_o, output_on_o}, 16'h0001);
    wt(0, 0);
    lift();
    $display("test special done");
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge mclk_i);
    cyc(1);
    rst_b_i = 1;
    cyc(1);
    chk({gas_o, motor_o, output_on_o, preset_o}, 16'h0000);
    test_setup();
    test_inch();
    test_nonlatched();
    test_latched(TTWS_LATCHED);
    test_latched(TTWS_LATCHED_SPECIAL);
    test_special();
    print_verdict();
  end
endmodule // test_torch_trigger_weld_sequencer

// [verif/ttws_seq_sva.sv]
// Port checker of the weld sequencer
`timescale 1ns/1ns
module ttws_seq_sva
  import ttws_pkg::*;
(
  input wire logic             mclk_i,
  input wire logic             rst_b_i,
  input wire logic             trigger_i,
  input wire logic             inch_i,
  input wire logic             contact_i,
  input wire logic             current_i,
  input wire ttws_mode_e       mode_i,
  input wire logic [1:0]       material_i,
  input wire logic             diameter_i,
  input wire logic             gas_type_i,
  input wire logic             preset_load_i,
  input wire logic             gas_o,
  input wire logic             motor_o,
  input wire logic             output_on_o,
  input wire ttws_prog_e       program_o,
  input wire logic             ramping_o,
  input wire ttws_preset_t     preset_o,
  input wire logic             preset_reject_o,
  input wire logic signed [7:0] arc_length_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // Sequence and setting checks
  a_inch_stop: assert property (inch_i && contact_i && !gas_o |=> !motor_o)
    else $error("wire motor kept running at contact");
  a_pre_flow: assert property ($rose(trigger_i) && !gas_o && !inch_i |=> gas_o && !motor_o)
    else $error("press did not start pre-flow");
  a_out_gas: assert property (output_on_o |-> gas_o)
    else $error("output on without gas");
  a_rel_stop: assert property ($fell(trigger_i) && mode_i == TTWS_NONLATCHED && current_i && motor_o
      |=> !motor_o && output_on_o)
    else $error("release did not stop wire");
  a_latch_press: assert property ($rose(trigger_i) && mode_i == TTWS_LATCHED && motor_o |=> motor_o)
    else $error("second press acted in latched mode");
  a_ramp_end: assert property (ramping_o |-> program_o == TTWS_PROG_END && motor_o)
    else $error("ramp without end program");
  a_preset_keep: assert property (preset_load_i && current_i |=> preset_reject_o && $stable(preset_o))
    else $error("preset changed under current");
  a_preset_form: assert property (preset_load_i && !current_i
      |=> preset_o == {$past(material_i), $past(diameter_i), $past(gas_type_i)})
    else $error("preset number wrongly formed");
  a_arc_range: assert property (arc_length_o >= -8'sd5 && arc_length_o <= 8'sd5)
    else $error("arc length out of range");
endmodule // ttws_seq_sva

bind ttws_seq ttws_seq_sva u_sva (.mclk_i, .rst_b_i, .trigger_i, .inch_i, .contact_i, .current_i,
  .mode_i, .material_i, .diameter_i, .gas_type_i, .preset_load_i, .gas_o, .motor_o,
  .output_on_o, .program_o, .ramping_o, .preset_o, .preset_reject_o, .arc_length_o);

// [verif/ttws_torch_model.sv]
// Torch, wire and work model: contact, current and arc
`timescale 1ns/1ns
module ttws_torch_model
#(
  parameter int DLY = 20
)
(
  input  wire logic mclk_i,
  input  wire logic motor_i,
  input  wire logic output_on_i,
  input  wire logic away_i,
  output logic      contact_o,
  output logic      current_o,
  output logic      arc_o
);
  int cnt = 0;
  // Wire travels while the motor runs; lifting the torch clears contact
  always_ff @(posedge mclk_i)
    if (away_i)
      cnt <= 0;
    else if (motor_i && cnt < DLY)
      cnt <= cnt + 1;
  // Current and arc only with wire at work and output on
  assign contact_o = !away_i && cnt >= DLY;
  assign current_o = contact_o && output_on_i;
  assign arc_o     = current_o;
endmodule // ttws_torch_model
